/* File: bench/mfdc_dispatch_test.sv */
`timescale 1ns/100ps
`include "mfdc_regs.svh"
module mfdc_dispatch_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        timer1_zero, timer1_active, frame_start, frame_manual, line_done, mf_seen;
    logic        table_end_irq, bus_timeout_irq, busy, slow, mute, e;
    logic [15:0] frame_addr, last_addr;
    logic [1:0]  man_hist;
    int          num_errors, samples_checked, cyc, nf, nte, nbt, f0, t0, b0;

    mfdc_dispatch #(.BUS_TMO_CYC(20)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .timer1_zero(timer1_zero),
        .timer1_active(timer1_active), .frame_start(frame_start), .frame_addr(frame_addr),
        .frame_manual(frame_manual), .line_done(line_done), .mf_seen(mf_seen),
        .table_end_irq(table_end_irq), .bus_timeout_irq(bus_timeout_irq), .busy(busy));
    mfdc_far_end far (.pclk(pclk), .presetn(presetn), .slow(slow), .mute(mute),
        .frame_start(frame_start), .mf_seen(mf_seen), .line_done(line_done));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // event tally and hang guard
    always @(posedge pclk) begin
        cyc++;
        if (frame_start === 1'b1) begin
            nf++;
            last_addr = frame_addr;
            man_hist = {man_hist[0], frame_manual};
        end
        if (table_end_irq === 1'b1) nte++;
        if (bus_timeout_irq === 1'b1) nbt++;
        if (cyc == 4000) begin
            num_errors++;
            print_verdict();
        end
    end

    task print_verdict();
        if (num_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; the request is held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(r, exp);
    endtask

    task settle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task tick(input logic act);
        @(posedge pclk);
        timer1_zero <= 1'b1;
        timer1_active <= act;
        @(posedge pclk);
        timer1_zero <= 1'b0;
    endtask

    task t_auto();
        apb(1'b1, `MFDC_PTR_OFF, 32'h10);
        apb(1'b1, `MFDC_NPTR_OFF, 32'h30);
        apb(1'b1, `MFDC_NEXT_OFF, 32'h0);
        f0 = nf;
        t0 = nte;
        apb(1'b1, `MFDC_CTRL_OFF, 32'h42);
        settle(60);
        check(nf - f0, 2);
        check(last_addr, 32'h11);
        check(nte - t0, 1);
        rd(`MFDC_PTR_OFF, 32'h30);
        rd(`MFDC_NEXT_OFF, 32'h0);
        rd(`MFDC_CTRL_OFF, 32'h0);
        f0 = nf;
        apb(1'b1, `MFDC_CTRL_OFF, 32'h40);
        settle(400);
        check(nf - f0, 32);
        check(last_addr, 32'h4F);
    endtask

    task t_timed();
        f0 = nf;
        apb(1'b1, `MFDC_CTRL_OFF, 32'h81);
        rd(`MFDC_CTRL_OFF, 32'h81);
        apb(1'b1, `MFDC_CTRL_OFF, 32'h0);
        apb(1'b1, `MFDC_CTRL_OFF, 32'hC1);
        rd(`MFDC_CTRL_OFF, 32'h81);
        tick(1'b0);
        rd(`MFDC_CTRL_OFF, 32'h81);
        check(nf - f0, 0);
        tick(1'b1);
        settle(30);
        check(nf - f0, 1);
        rd(`MFDC_CTRL_OFF, 32'h0);
    endtask

    task t_empty();
        apb(1'b1, `MFDC_NEXT_OFF, 32'h41);
        apb(1'b1, `MFDC_NPTR_OFF, 32'h20);
        f0 = nf;
        t0 = nte;
        apb(1'b1, `MFDC_CTRL_OFF, 32'hC0);
        rd(`MFDC_CTRL_OFF, 32'hC0);
        settle(20);
        check(nf - f0, 0);
        tick(1'b1);
        settle(30);
        check(nte - t0, 2);
        check(last_addr, 32'h20);
    endtask

    // cancel lands while the first slow telegram is still on the line
    task t_cancel();
        slow <= 1'b1;
        f0 = nf;
        apb(1'b1, `MFDC_CTRL_OFF, 32'h40);
        apb(1'b1, `MFDC_CTRL_OFF, 32'h160);
        apb(1'b0, `MFDC_CTRL_OFF, 32'h0);
        check(r & 32'h1E0, 32'h0);
        settle(60);
        check(nf - f0, 1);
        slow <= 1'b0;
    endtask

    task t_tmo();
        mute <= 1'b1;
        b0 = nbt;
        apb(1'b1, `MFDC_CTRL_OFF, 32'h41);
        settle(40);
        check(nbt - b0, 1);
        check(busy, 1'b0);
        rd(`MFDC_STAT_OFF, 32'h6);
        apb(1'b1, `MFDC_STAT_OFF, 32'h6);
        rd(`MFDC_STAT_OFF, 32'h0);
        mute <= 1'b0;
        apb(1'b0, 8'h20, 32'h0);
        check(e, 1'b1);
        check(r, 32'h0);
    endtask

    // manual request waits behind the running table, then goes alone
    task t_manual();
        f0 = nf;
        apb(1'b1, `MFDC_CTRL_OFF, 32'h61);
        settle(40);
        check(nf - f0, 2);
        check(man_hist, 2'h1);
        check(last_addr, 32'h0);
        rd(`MFDC_CTRL_OFF, 32'h0);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, timer1_zero, timer1_active, slow, mute} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        settle(6);
        presetn <= 1'b1;
        rd(`MFDC_CTRL_OFF, 32'h0);
        t_auto();
        t_timed();
        t_empty();
        t_cancel();
        t_tmo();
        t_manual();
        print_verdict();
    end
endmodule

/* File: bench/mfdc_far_end.sv */
`timescale 1ns/100ps
// far side: frame encoder and decoder answering each master frame
module mfdc_far_end (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control from bench
    input  wire logic slow,
    input  wire logic mute,
    // frame link
    input  wire logic frame_start,
    output logic      mf_seen,
    output logic      line_done
);
    logic [3:0] cnt_ff;
    logic       act_ff;

    // one telegram at a time; a muted line never answers, so the watchdog must fire
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_ff    <= 1'b0;
            cnt_ff    <= 4'h0;
            mf_seen   <= 1'b0;
            line_done <= 1'b0;
        end else begin
            mf_seen   <= 1'b0;
            line_done <= 1'b0;
            if (frame_start && !mute) begin
                act_ff <= 1'b1;
                cnt_ff <= slow ? 4'hF : 4'h3;
            end else if (act_ff) begin
                cnt_ff <= cnt_ff - 4'h1;
                mf_seen <= (cnt_ff == 4'h2);
                if (cnt_ff == 4'h0) begin
                    line_done <= 1'b1;
                    act_ff    <= 1'b0;
                end
            end
        end
    end
endmodule

/* File: verilog/mfdc_dispatch.sv */
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "mfdc_regs.svh"
module mfdc_dispatch #(
    parameter int unsigned AW          = 8,
    parameter int unsigned PW          = 16,
    parameter int unsigned BUS_TMO_CYC = `MFDC_BUS_TMO_CYC
) (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    // universal timer 1
    input  wire logic          timer1_zero,
    input  wire logic          timer1_active,
    // frame encoder and decoder
    output logic               frame_start,
    output logic [PW-1:0]      frame_addr,
    output logic               frame_manual,
    input  wire logic          line_done,
    input  wire logic          mf_seen,
    // events and status
    output logic               table_end_irq,
    output logic               bus_timeout_irq,
    output logic               busy
);
    mfdc_pkg::mfdc_state_t state_ff;
    mfdc_pkg::mfdc_state_t nxt_state;
    logic [1:0]    req_ff;
    logic [4:0]    cnt_ff;
    logic          man_ff;
    logic [7:0]    sec_ctrl_ff;
    logic [PW-1:0] ptr_ff;
    logic [PW-1:0] sec_ptr_ff;
    logic [5:0]    remain_ff;
    logic [4:0]    idx_ff;
    logic          pready_ff;
    logic          pslverr_ff;
    logic [31:0]   prdata_ff;
    logic          start_ff;
    logic          manual_ff;
    logic [PW-1:0] addr_ff;
    logic          tend_ff;
    logic          btmo_ff;
    logic          busy_ff;
    logic          tend_st_ff;
    logic          btmo_st_ff;

    logic [AW-1:0] waddr;
    logic [31:0]   rd_mux;
    logic          addr_ok;
    logic          setup;
    logic          wr_acc;
    logic          wr_ctrl;
    logic          wr_next;
    logic          wr_ptr;
    logic          wr_nptr;
    logic          wr_stat;
    logic [1:0]    wr_req;
    logic          cancel;
    logic          tmr_hit;
    logic          tmo_hit;
    logic          frame_fin;
    logic          tbl_fin;
    logic          last_fin;
    logic          tend;
    logic          go_table;
    logic          go_man;
    logic [4:0]    tbl_idx;

    // every output straight from a flip-flop
    assign pready          = pready_ff;
    assign prdata          = prdata_ff;
    assign pslverr         = pslverr_ff;
    assign frame_start     = start_ff;
    assign frame_addr      = addr_ff;
    assign frame_manual    = manual_ff;
    assign table_end_irq   = tend_ff;
    assign bus_timeout_irq = btmo_ff;
    assign busy            = busy_ff;

    // bus decode; writes land only at the completing access edge
    assign waddr   = {paddr[AW-1:2], 2'h0};
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite && pready_ff;
    assign wr_ctrl = wr_acc && (waddr == AW'(`MFDC_CTRL_OFF));
    assign wr_next = wr_acc && (waddr == AW'(`MFDC_NEXT_OFF));
    assign wr_ptr  = wr_acc && (waddr == AW'(`MFDC_PTR_OFF));
    assign wr_nptr = wr_acc && (waddr == AW'(`MFDC_NPTR_OFF));
    assign wr_stat = wr_acc && (waddr == AW'(`MFDC_STAT_OFF));
    assign wr_req  = pwdata[`MFDC_REQ_MSB:`MFDC_REQ_LSB];
    assign cancel  = wr_ctrl && pwdata[`MFDC_CANCEL_BIT];

    // dispatch events; timer pulse is on-chip and shares this clock
    assign tmr_hit   = timer1_zero && timer1_active;                 // [RULE8] [RULE19]
    assign frame_fin = (state_ff == mfdc_pkg::st_wait) && (line_done || tmo_hit);
    assign tbl_fin   = frame_fin && !manual_ff && (req_ff == `MFDC_REQ_AUTO);
    assign last_fin  = tbl_fin && (remain_ff == 6'h01);
    assign tend      = !cancel && (last_fin ||
                       ((req_ff == `MFDC_REQ_EMPTY) && tmr_hit));    // [RULE6] [RULE11]
    assign go_table  = (state_ff == mfdc_pkg::st_idle) && !cancel &&
                       (req_ff == `MFDC_REQ_AUTO);                   // [RULE4] [RULE2] [RULE10]
    // manual frame yields to a running table until that table ends
    assign go_man    = (state_ff == mfdc_pkg::st_idle) && !cancel && man_ff &&
                       (req_ff != `MFDC_REQ_AUTO);                   // [RULE17]
    assign tbl_idx   = (remain_ff == 6'h00) ? 5'h00 : idx_ff;

    // register read mux, unmapped words read zero and flag an error
    always_comb begin
        rd_mux  = 32'h0000_0000;
        addr_ok = 1'h1;
        case (waddr)
            AW'(`MFDC_CTRL_OFF): rd_mux[7:0] = {req_ff, man_ff, cnt_ff};  // [RULE14] [RULE1]
            AW'(`MFDC_NEXT_OFF): rd_mux[7:0] = sec_ctrl_ff;
            AW'(`MFDC_PTR_OFF):  rd_mux[PW-1:0] = ptr_ff;
            AW'(`MFDC_NPTR_OFF): rd_mux[PW-1:0] = sec_ptr_ff;
            AW'(`MFDC_STAT_OFF): begin
                rd_mux[`MFDC_ST_BUSY] = busy_ff;
                rd_mux[`MFDC_ST_TEND] = tend_st_ff;
                rd_mux[`MFDC_ST_BTMO] = btmo_st_ff;
            end
            default: addr_ok = 1'h0;
        endcase
    end

    // no wait states: answer prepared in setup, access ends on its first cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'h0;
            pslverr_ff <= 1'h0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !addr_ok;
            if (setup && !pwrite) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    // pending request code; cancel beats everything, even the same write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_ff <= `MFDC_REQ_NONE;
        end else if (cancel) begin
            req_ff <= `MFDC_REQ_NONE;                                // [RULE1] [RULE20]
        end else if (tend) begin
            req_ff <= sec_ctrl_ff[`MFDC_REQ_MSB:`MFDC_REQ_LSB];      // [RULE5] [RULE7]
        end else if ((req_ff == `MFDC_REQ_TIMED) && tmr_hit) begin
            req_ff <= `MFDC_REQ_AUTO;                                // [RULE9] [RULE8]
        end else if (wr_ctrl && (req_ff == `MFDC_REQ_NONE)) begin
            req_ff <= wr_req;                                        // [RULE12] [RULE13] [RULE14]
        end
    end

    // table count: loaded with an accepted request or at table end, drops per table frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 5'h00;
        end else if (tend) begin
            cnt_ff <= sec_ctrl_ff[`MFDC_CNT_MSB:`MFDC_CNT_LSB];
        end else if (wr_ctrl && !cancel && (req_ff == `MFDC_REQ_NONE) &&
                     (wr_req != `MFDC_REQ_NONE)) begin
            cnt_ff <= pwdata[`MFDC_CNT_MSB:`MFDC_CNT_LSB];
        end else if (tbl_fin && !cancel) begin
            cnt_ff <= cnt_ff - 5'h01;                                // [RULE15]
        end
    end

    // manual frame request; a software set wins over the hardware clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            man_ff <= 1'h0;
        end else if (cancel) begin
            man_ff <= 1'h0;                                          // [RULE1]
        end else if (wr_ctrl && pwdata[`MFDC_MAN_BIT]) begin
            man_ff <= 1'h1;
        end else if (tend && sec_ctrl_ff[`MFDC_MAN_BIT]) begin
            man_ff <= 1'h1;
        end else if (go_man) begin
            man_ff <= 1'h0;
        end
    end

    // secondary control word, emptied once it has moved across
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_ctrl_ff <= `MFDC_CTRL_RST;
        end else if (wr_next) begin
            sec_ctrl_ff <= pwdata[7:0];
        end else if (tend) begin
            sec_ctrl_ff <= `MFDC_CTRL_RST;                           // [RULE16]
        end
    end

    // table pointers; the hardware swap wins over a racing software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_ff     <= '0;
            sec_ptr_ff <= '0;
        end else begin
            if (tend) begin
                ptr_ff <= sec_ptr_ff;                                // [RULE7] [RULE11]
            end else if (wr_ptr) begin
                ptr_ff <= pwdata[PW-1:0];
            end
            if (wr_nptr) begin
                sec_ptr_ff <= pwdata[PW-1:0];
            end
        end
    end

    // table walk: remaining entries and index of the next entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain_ff <= 6'h00;
            idx_ff    <= 5'h00;
        end else if (cancel || tend) begin
            remain_ff <= 6'h00;                                      // [RULE2]
            idx_ff    <= 5'h00;
        end else if (go_table && (remain_ff == 6'h00)) begin
            remain_ff <= (cnt_ff == 5'h00) ? `MFDC_FULL_TABLE
                                           : {1'h0, cnt_ff};         // [RULE4] [RULE15]
            idx_ff    <= 5'h01;
        end else if (tbl_fin) begin
            remain_ff <= remain_ff - 6'h01;
        end else if (go_table) begin
            idx_ff    <= idx_ff + 5'h01;
        end
    end

    // state: a frame in flight always runs to its end, even after cancel
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            mfdc_pkg::st_idle: if (go_table || go_man) nxt_state = mfdc_pkg::st_wait;
            mfdc_pkg::st_wait: if (frame_fin) nxt_state = mfdc_pkg::st_idle;     // [RULE3]
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= mfdc_pkg::st_idle;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // frame issue to the encoder, one pulse per frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_ff  <= 1'h0;
            manual_ff <= 1'h0;
            addr_ff   <= '0;
        end else begin
            start_ff <= go_table || go_man;
            if (go_table || go_man) begin
                manual_ff <= go_man;
                addr_ff   <= go_table ? ptr_ff + PW'(tbl_idx) : '0;
            end
        end
    end

    // watchdog on the decoder seeing our own frame
    mfdc_tmo_cnt #(
        .CYCLES (BUS_TMO_CYC),
        .CW     (32)
    ) u_tmo (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (go_table || go_man),
        .stop    (mf_seen || line_done),
        .expired (tmo_hit)                                           // [RULE18]
    );

    // event pulses, sticky copies and busy; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tend_ff    <= 1'h0;
            btmo_ff    <= 1'h0;
            busy_ff    <= 1'h0;
            tend_st_ff <= 1'h0;
            btmo_st_ff <= 1'h0;
        end else begin
            tend_ff    <= tend;                                      // [RULE6] [RULE11]
            btmo_ff    <= tmo_hit;                                   // [RULE18]
            busy_ff    <= (nxt_state == mfdc_pkg::st_wait) ||
                          (req_ff == `MFDC_REQ_AUTO && !cancel && !tend);
            tend_st_ff <= tend || (tend_st_ff && !(wr_stat && pwdata[`MFDC_ST_TEND]));
            btmo_st_ff <= tmo_hit || (btmo_st_ff && !(wr_stat && pwdata[`MFDC_ST_BTMO]));
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cancel;
        cancel;
    endsequence
    sequence s_last_frame;
        last_fin && !cancel;
    endsequence
    sequence s_timer_done;
        tmr_hit && !cancel;
    endsequence

    a_cancel_clears: assert property ( // [RULE1] [RULE20]
        s_cancel |=> req_ff == `MFDC_REQ_NONE && !man_ff && remain_ff == 6'h00)
        else $error("cancel left a request pending");
    a_cancel_reads_zero: assert property ( // [RULE1]
        setup && !pwrite && waddr == AW'(`MFDC_CTRL_OFF) |=> !prdata_ff[`MFDC_CANCEL_BIT])
        else $error("cancel bit read as one");
    a_cancel_no_frame: assert property ( // [RULE2]
        s_cancel |=> !start_ff)
        else $error("frame issued after cancel");
    a_cancel_drains: assert property ( // [RULE3]
        state_ff == mfdc_pkg::st_wait && cancel && !frame_fin |=> state_ff == mfdc_pkg::st_wait)
        else $error("telegram in flight was dropped");
    a_auto_start: assert property ( // [RULE4]
        go_table && remain_ff == 6'h00 |=> start_ff && !manual_ff && addr_ff == $past(ptr_ff))
        else $error("table did not start at the pointer");
    a_zero_is_full: assert property ( // [RULE15]
        go_table && remain_ff == 6'h00 && cnt_ff == 5'h00 |=> remain_ff == `MFDC_FULL_TABLE)
        else $error("count zero not taken as 32");
    a_count_step: assert property ( // [RULE15]
        tbl_fin && !cancel && !tend |=> cnt_ff == $past(cnt_ff) - 5'h01)
        else $error("count did not drop by one");
    a_last_end: assert property ( // [RULE6]
        s_last_frame |=> tend_ff ##1 !tend_ff)
        else $error("no single table end pulse");
    a_swap_regs: assert property ( // [RULE7] [RULE16] [RULE5]
        tend && !wr_next |=> ptr_ff == $past(sec_ptr_ff) && sec_ctrl_ff == 8'h00 &&
            req_ff == $past(sec_ctrl_ff[`MFDC_REQ_MSB:`MFDC_REQ_LSB]))
        else $error("table end transfer wrong");
    a_timed_hold: assert property ( // [RULE8] [RULE19]
        req_ff == `MFDC_REQ_TIMED && !tmr_hit && !cancel |=> req_ff == `MFDC_REQ_TIMED)
        else $error("timed request left early");
    a_timed_auto: assert property ( // [RULE9]
        req_ff == `MFDC_REQ_TIMED and s_timer_done |=> req_ff == `MFDC_REQ_AUTO)
        else $error("timed request not turned automatic");
    a_empty_silent: assert property ( // [RULE10]
        req_ff == `MFDC_REQ_EMPTY |=> !(start_ff && !manual_ff))
        else $error("table frame sent in empty slot");
    a_empty_end: assert property ( // [RULE11]
        req_ff == `MFDC_REQ_EMPTY and s_timer_done |=> tend_ff)
        else $error("empty slot did not end on timer");
    a_req_locked: assert property ( // [RULE12] [RULE13]
        wr_ctrl && !cancel && req_ff != `MFDC_REQ_NONE && !tend &&
            !(req_ff == `MFDC_REQ_TIMED && tmr_hit) |=> req_ff == $past(req_ff))
        else $error("pending request overwritten");
    a_zero_write: assert property ( // [RULE14]
        wr_ctrl && req_ff == `MFDC_REQ_NONE && wr_req == `MFDC_REQ_NONE
            |=> req_ff == `MFDC_REQ_NONE)
        else $error("writing 00 made a request");
    a_manual_waits: assert property ( // [RULE17]
        state_ff == mfdc_pkg::st_idle && req_ff == `MFDC_REQ_AUTO |=> !(start_ff && manual_ff))
        else $error("manual frame cut into table");
    a_bus_timeout: assert property ( // [RULE18]
        tmo_hit |=> btmo_ff && state_ff == mfdc_pkg::st_idle)
        else $error("bus timeout not flagged");
endmodule

/* File: verilog/mfdc_pkg.sv */
package mfdc_pkg;
    // dispatcher is either free or waiting for the telegram in flight
    typedef enum logic {
        st_idle,
        st_wait
    } mfdc_state_t;
endpackage

/* File: verilog/mfdc_regs.svh */
`ifndef MFDC_REGS_SVH
`define MFDC_REGS_SVH
// Notes on behaviour
// RULE1: writing cancel one clears all pending requests; zero does nothing; reads zero
// RULE2: cancel aborts a scheduled dispatch and a table already running
// RULE3: a telegram on the line finishes, then no further frame is sent
// RULE4: code 01 starts the table at the pointer now, count from count field
// RULE5: device sets automatic request on timer expiry of timed, and on table end; code loads the request code of the secondary control word at table end
// RULE6: last table entry processed raises the table end event
// RULE7: table end copies secondary pointer and secondary control word into primary
// RULE8: code 10 holds table start until active timer reaches zero
// RULE9: timer expiry turns timed code into automatic code, then proceeds identically
// RULE10: code 11 sends no frames and waits for timer zero
// RULE11: timer zero during empty slot raises table end with register transfer
// RULE12: only one request code is pending; it is accepted and held
// RULE13: different request code written while pending is ignored until done or cancel
// RULE14: writing 00 has no effect; reads return the pending request code
// RULE15: count zero means 32 entries; count drops by one per frame sent
// RULE16: secondary control word clears to zero after moving to primary
// RULE17: manual frame request during a table is sent after the table completes
// RULE18: frame not seen by decoder gives bus timeout after 1.3 ms, busy cleared; code keeps busy set while an automatic table has entries left
// RULE19: timed or empty request waits indefinitely while the timer is inactive
// RULE20: cancel and new request in one write leave nothing pending
// register byte offsets
`define MFDC_CTRL_OFF    8'h00
`define MFDC_NEXT_OFF    8'h04
`define MFDC_PTR_OFF     8'h08
`define MFDC_NPTR_OFF    8'h0C
`define MFDC_STAT_OFF    8'h10
// control word fields
`define MFDC_CNT_MSB     4
`define MFDC_CNT_LSB     0
`define MFDC_MAN_BIT     5
`define MFDC_REQ_MSB     7
`define MFDC_REQ_LSB     6
`define MFDC_CANCEL_BIT  8
// request codes
`define MFDC_REQ_NONE    2'h0
`define MFDC_REQ_AUTO    2'h1
`define MFDC_REQ_TIMED   2'h2
`define MFDC_REQ_EMPTY   2'h3
// status bits
`define MFDC_ST_BUSY     0
`define MFDC_ST_TEND     1
`define MFDC_ST_BTMO     2
// reset values and table size
`define MFDC_CTRL_RST    8'h00
`define MFDC_FULL_TABLE  6'h20
// timing
`define MFDC_CLK_NS      50
`define MFDC_BUS_TMO_NS  1300000
`define MFDC_BUS_TMO_CYC (`MFDC_BUS_TMO_NS / `MFDC_CLK_NS)
`endif

/* File: verilog/mfdc_tmo_cnt.sv */
`timescale 1ns/100ps
`include "mfdc_regs.svh"
module mfdc_tmo_cnt #(
    parameter int unsigned CYCLES = `MFDC_BUS_TMO_CYC,
    parameter int unsigned CW     = 16
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic start,
    input  wire logic stop,
    // result
    output logic      expired
);
    logic [CW-1:0] cnt_ff;
    logic          run_ff;

    // down counter armed per frame; a restart wins over a stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
            run_ff <= 1'h0;
        end else if (start) begin
            cnt_ff <= CW'(CYCLES - 1);
            run_ff <= 1'h1;
        end else if (stop || (run_ff && cnt_ff == '0)) begin
            run_ff <= 1'h0;
        end else if (run_ff) begin
            cnt_ff <= cnt_ff - 1'h1;
        end
    end

    // a late decoder answer in the last cycle still counts as seen
    assign expired = run_ff && (cnt_ff == '0) && !stop;
endmodule
